// ===== core/isam_top.sv
/*
 * Status flags, address mask and slave address recogniser of a
 * two-wire bus controller, with a register port and one interrupt.
 * Assumes the shift engine reports master collision and transmit done as
 * one-cycle pulses on clk_sys, busy as a level, and that pins are async.
 */
`timescale 1ns/10ps
module isam_top
	import isam_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	input  wire logic        sclPin,
	input  wire logic        sdaPin,
	input  wire logic        masterCollision,
	input  wire logic        txDone,
	input  wire logic        txBusy,
	output logic      [7:0]  txByte,
	output logic             txStart,
	output logic             addrHit,
	output logic             irq
);
	typedef struct packed
	{
		logic [15:0]   status;
		logic [9:0]    mask;
		logic [9:0]    ownAddr;
		logic          ten;
		logic [7:0]    rxHold;
		logic [7:0]    txHold;
		logic [15:0]   rdata;
		logic          txStart;
		logic          hit;
		isam_slv_t     slv;
		logic [3:0]    bitCnt;
		logic [7:0]    shift;
		logic [7:0]    firstByte;
		logic          phase2;
		logic [EV_W-1:0] evStat;
		logic [EV_W-1:0] evMask;
		logic          irq;
	} isam_st_t;

	isam_st_t st_reg;
	isam_st_t st_next;

	logic [1:0] pinSync;
	isam_cond_t cond;
	isam_bus_t  bus;

	isam_sync #(.W(2)) uSync
	(
		.clk_sys (clk_sys),
		.srst    (srst),
		.din     ({sclPin, sdaPin}),
		.dout    (pinSync)
	);

	isam_cond uCond
	(
		.clk_sys (clk_sys),
		.srst    (srst),
		.sclIn   (pinSync[1]),
		.sdaIn   (pinSync[0]),
		.cond    (cond)
	);

	always_comb
	begin
		bus.wrStb = regWr;
		bus.rdStb = regRd;
		bus.addr  = regAddr;
		bus.wdata = regWdata;
	end

	// current byte with the sampled bit appended
	logic [7:0] byteNow;
	logic [9:0] rxAddr;
	logic       byteEnd;
	logic       addrOk;
	logic       gcOk;
	logic       ovfSet;
	logic [EV_W-1:0] ev;

	always_comb
	begin
		byteNow = {st_reg.shift[6:0], cond.sdaLevel};
		byteEnd = cond.sclRise && st_reg.bitCnt == BIT_COUNT_LAST - 4'h1;
		rxAddr  = st_reg.ten ? {st_reg.firstByte[2:1], byteNow}
			: {3'b000, byteNow[7:1]};
		addrOk  = addrMatch(rxAddr, st_reg.ownAddr, st_reg.mask);
		gcOk    = !st_reg.ten && byteNow == GCALL_ADDR;
		// a byte landing on a full holding register
		ovfSet  = byteEnd && st_reg.slv == SL_DATA
			&& !st_reg.status[BIT_DIR] && st_reg.status[BIT_RXFULL];
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.txStart = 1'b0;
		st_next.rdata   = 16'h0000;
		ev = '0;

		// bit clock and byte framing for the address recogniser
		// the ninth clock carries acknowledge and only rewinds the count
		if (cond.sclRise && st_reg.slv != SL_IDLE)
		begin
			if (st_reg.bitCnt == BIT_COUNT_LAST)
				st_next.bitCnt = 4'h0;
			else
			begin
				st_next.shift  = byteNow;
				st_next.bitCnt = st_reg.bitCnt + 4'h1;
			end
		end

		if (byteEnd)
		begin
			case (st_reg.slv)
			SL_ADDR1:
			begin
				st_next.firstByte = byteNow;
				if (st_reg.ten && byteNow[7:3] == TENBIT_HDR)
				begin
					if (st_reg.phase2 && byteNow[0])
					begin
						st_next.status[BIT_DIR] = 1'b1;
						st_next.status[BIT_DATA] = 1'b0;
						st_next.hit = 1'b1;
						st_next.slv = SL_DATA;
					end
					else
						st_next.slv = SL_ADDR2;
				end
				else if (!st_reg.ten && (addrOk || gcOk))
				begin
					st_next.status[BIT_DIR]  = byteNow[0];
					st_next.status[BIT_DATA] = 1'b0;
					st_next.status[BIT_GCALL] = gcOk;
					st_next.hit = 1'b1;
					st_next.slv = SL_DATA;
				end
				else
					st_next.slv = SL_SKIP;
			end
			SL_ADDR2:
			begin
				if (addrOk)
				begin
					st_next.status[BIT_TENBIT] = 1'b1;
					st_next.status[BIT_DIR]  = 1'b0;
					st_next.status[BIT_DATA] = 1'b0;
					st_next.hit    = 1'b1;
					st_next.phase2 = 1'b1;
					st_next.slv    = SL_DATA;
				end
				else
					st_next.slv = SL_SKIP;
			end
			SL_DATA:
			begin
				// slave write data lands in the holding register unless it is still full
				if (!st_reg.status[BIT_DIR])
				begin
					st_next.status[BIT_DATA] = 1'b1;
					if (st_reg.status[BIT_RXFULL])
						st_next.status[BIT_RXOVF] = 1'b1;
					else
					begin
						st_next.rxHold = byteNow;
						st_next.status[BIT_RXFULL] = 1'b1;
						ev[EV_RXBYTE] = 1'b1;
					end
				end
			end
			default:
			begin
			end
			endcase
		end

		if (cond.startDet)
		begin
			st_next.status[BIT_START] = 1'b1;
			st_next.status[BIT_STOP]  = 1'b0;
			st_next.slv    = SL_ADDR1;
			st_next.bitCnt = 4'h0;
			st_next.hit    = 1'b0;
			ev[EV_START]   = 1'b1;
		end
		if (cond.stopDet)
		begin
			st_next.status[BIT_STOP]   = 1'b1;
			st_next.status[BIT_START]  = 1'b0;
			st_next.status[BIT_GCALL]  = 1'b0;
			st_next.status[BIT_TENBIT] = 1'b0;
			st_next.slv    = SL_IDLE;
			st_next.hit    = 1'b0;
			st_next.phase2 = 1'b0;
			ev[EV_STOP]    = 1'b1;
		end

		if (txDone)
		begin
			st_next.status[BIT_TXFULL] = 1'b0;
			ev[EV_TXDONE] = 1'b1;
		end

		// register reads
		if (bus.rdStb)
		begin
			case (bus.addr)
			OFF_STATUS:  st_next.rdata = st_reg.status;
			OFF_MASK:    st_next.rdata = {6'h00, st_reg.mask};
			OFF_RXHOLD:
			begin
				st_next.rdata = {8'h00, st_reg.rxHold};
				if (!ev[EV_RXBYTE])
					st_next.status[BIT_RXFULL] = 1'b0;
			end
			OFF_TXHOLD:  st_next.rdata = {8'h00, st_reg.txHold};
			OFF_SLVADDR: st_next.rdata = {5'h00, st_reg.ten, st_reg.ownAddr};
			OFF_IRQSTAT: st_next.rdata = {10'h000, st_reg.evStat};
			OFF_IRQMASK: st_next.rdata = {10'h000, st_reg.evMask};
			default:     st_next.rdata = 16'h0000;
			endcase
		end

		// register writes; software clears lose to a same-cycle set
		if (bus.wrStb)
		begin
			case (bus.addr)
			OFF_STATUS:
			begin
				if (bus.wdata[BIT_BUSCOL] && !masterCollision)
					st_next.status[BIT_BUSCOL] = 1'b0;
				if (bus.wdata[BIT_RXOVF] && !ovfSet)
					st_next.status[BIT_RXOVF] = 1'b0;
				if (bus.wdata[BIT_WCOL])
					st_next.status[BIT_WCOL] = 1'b0;
			end
			OFF_MASK:    st_next.mask = bus.wdata[9:0] & MASK_IMPL[9:0];
			OFF_TXHOLD:
			begin
				if (txBusy || st_reg.status[BIT_TXFULL])
					st_next.status[BIT_WCOL] = 1'b1;
				else
				begin
					st_next.txHold  = bus.wdata[7:0];
					st_next.status[BIT_TXFULL] = 1'b1;
					st_next.txStart = 1'b1;
				end
			end
			OFF_SLVADDR:
			begin
				st_next.ownAddr = bus.wdata[9:0];
				st_next.ten     = bus.wdata[10];
			end
			OFF_IRQSTAT: st_next.evStat = st_reg.evStat & ~bus.wdata[EV_W-1:0];
			OFF_IRQMASK: st_next.evMask = bus.wdata[EV_W-1:0];
			default:
			begin
			end
			endcase
		end

		if (masterCollision)
		begin
			st_next.status[BIT_BUSCOL] = 1'b1;
			ev[EV_BUSCOL] = 1'b1;
		end
		ev[EV_ERR] = st_next.status[BIT_RXOVF] & ~st_reg.status[BIT_RXOVF]
			| st_next.status[BIT_WCOL] & ~st_reg.status[BIT_WCOL];

		// sticky events win over the write-one clear
		st_next.evStat = st_next.evStat | ev;
		st_next.irq = |(st_next.evStat & st_next.evMask);
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			st_reg <= '0;
			st_reg.status  <= RST_STATUS;
			st_reg.mask    <= RST_MASK[9:0];
			st_reg.ownAddr <= RST_SLVADDR;
			st_reg.slv     <= SL_IDLE;
		end
		else
			st_reg <= st_next;
	end

	assign regRdata = st_reg.rdata;
	assign txByte   = st_reg.txHold;
	assign txStart  = st_reg.txStart;
	assign addrHit  = st_reg.hit;
	assign irq      = st_reg.irq;

	default clocking cbAst @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	AST_COLSET: assert property (masterCollision
		|=> st_reg.status[BIT_BUSCOL] && st_reg.evStat[EV_BUSCOL])
		else $error("collision flag not set");
	AST_COLHW: assert property (masterCollision && regWr
		|=> st_reg.status[BIT_BUSCOL])
		else $error("collision lost to clear");
	AST_STARTF: assert property (cond.startDet && !cond.stopDet
		|=> st_reg.status[BIT_START] && !st_reg.status[BIT_STOP])
		else $error("start flag wrong");
	AST_STOPF: assert property (cond.stopDet
		|=> st_reg.status[BIT_STOP] && !st_reg.status[BIT_START]
		&& !st_reg.status[BIT_GCALL])
		else $error("stop flag wrong");
	AST_EXCL: assert property (
		!(st_reg.status[BIT_START] && st_reg.status[BIT_STOP]))
		else $error("start and stop both set");
	AST_RXSET: assert property ($rose(st_reg.status[BIT_RXFULL])
		|-> $past(byteEnd))
		else $error("receive full without byte");
	AST_RXCLR: assert property (regRd && regAddr == OFF_RXHOLD
		&& !ev[EV_RXBYTE] |=> !st_reg.status[BIT_RXFULL])
		else $error("receive full not cleared");
	sequence txWrite;
		regWr && regAddr == OFF_TXHOLD && !txBusy
		&& !st_reg.status[BIT_TXFULL];
	endsequence
	AST_TXSET: assert property (txWrite and !txDone
		|=> st_reg.status[BIT_TXFULL] && txStart)
		else $error("transmit full not set");
	AST_TXCLR: assert property (txDone
		|=> !st_reg.status[BIT_TXFULL])
		else $error("transmit full not cleared");
	AST_MASKRD: assert property (regRd && regAddr == OFF_MASK
		|=> regRdata[15:10] == 6'h00 && regRdata[9:0] == st_reg.mask)
		else $error("mask readback wrong");
	AST_WCOL: assert property (regWr && regAddr == OFF_TXHOLD
		&& txBusy |=> st_reg.status[BIT_WCOL])
		else $error("write collision missed");
	AST_OVFSET: assert property (ovfSet |=> st_reg.status[BIT_RXOVF])
		else $error("overflow lost to clear");
	AST_DATA: assert property ($rose(st_reg.status[BIT_DATA])
		|-> $past(byteEnd))
		else $error("data flag without byte");
endmodule

// ===== core/isam_pkg.sv
/*
 * Package for the two-wire status flag and address mask block.
 * Register offsets, bit positions, reset values and shared types.
 * Assumes a 16-bit register port with word offsets.
 */
package isam_pkg;

	localparam int ISAM_AW = 4;
	localparam logic [3:0] OFF_STATUS   = 4'h0;
	localparam logic [3:0] OFF_MASK     = 4'h1;
	localparam logic [3:0] OFF_RXHOLD   = 4'h2;
	localparam logic [3:0] OFF_TXHOLD   = 4'h3;
	localparam logic [3:0] OFF_SLVADDR  = 4'h4;
	localparam logic [3:0] OFF_IRQSTAT  = 4'h5;
	localparam logic [3:0] OFF_IRQMASK  = 4'h6;

	localparam int BIT_TXFULL   = 0;
	localparam int BIT_RXFULL   = 1;
	localparam int BIT_DIR      = 2;
	localparam int BIT_START    = 3;
	localparam int BIT_STOP     = 4;
	localparam int BIT_DATA     = 5;
	localparam int BIT_RXOVF    = 6;
	localparam int BIT_WCOL     = 7;
	localparam int BIT_TENBIT   = 8;
	localparam int BIT_GCALL    = 9;
	localparam int BIT_BUSCOL   = 10;

	localparam logic [15:0] RST_STATUS  = 16'h0000;
	localparam logic [15:0] RST_MASK    = 16'h0000;
	localparam logic [15:0] MASK_IMPL   = 16'h03FF;
	localparam logic [9:0]  RST_SLVADDR = 10'h000;
	localparam logic [7:0]  GCALL_ADDR  = 8'h00;
	localparam logic [4:0]  TENBIT_HDR  = 5'h1E;
	localparam logic [3:0]  BIT_COUNT_LAST = 4'h8;

	// interrupt status layout
	localparam int EV_START  = 0;
	localparam int EV_STOP   = 1;
	localparam int EV_RXBYTE = 2;
	localparam int EV_BUSCOL = 3;
	localparam int EV_TXDONE = 4;
	localparam int EV_ERR    = 5;
	localparam int EV_W      = 6;

	typedef struct packed
	{
		logic       wrStb;
		logic       rdStb;
		logic [3:0] addr;
		logic [15:0] wdata;
	} isam_bus_t;

	typedef struct packed
	{
		logic startDet;
		logic stopDet;
		logic sclRise;
		logic sclFall;
		logic sdaLevel;
		logic sclLevel;
	} isam_cond_t;

	typedef enum logic [2:0]
	{
		SL_IDLE,
		SL_ADDR1,
		SL_ADDR2,
		SL_ACK,
		SL_DATA,
		SL_SKIP
	} isam_slv_t;

	function automatic logic addrMatch(input logic [9:0] rxa,
		input logic [9:0] own, input logic [9:0] msk);
		return ((rxa ^ own) & ~msk) == 10'h000;
	endfunction

endpackage

// ===== core/isam_sync.sv
/*
 * Two-flop synchroniser for the bus pins.
 * Assumes pin inputs are asynchronous to clk_sys.
 */
`timescale 1ns/10ps
module isam_sync
	import isam_pkg::*;
#(
	parameter int W = 2
)
(
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} isam_syn_t;

	isam_syn_t st_reg;
	isam_syn_t st_next;

	always_comb
	begin
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_sys)
	begin
		// idle bus is high
		if (srst)
			st_reg <= '1;
		else
			st_reg <= st_next;
	end

	assign dout = st_reg.s2;
endmodule

// ===== core/isam_cond.sv
/*
 * Start, Stop and clock edge detector on synchronised pin levels.
 * Assumes inputs already pass two flops in clk_sys.
 */
`timescale 1ns/10ps
module isam_cond
	import isam_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic sclIn,
	input  wire logic sdaIn,
	output isam_cond_t cond
);
	typedef struct packed
	{
		logic sclD;
		logic sdaD;
	} isam_cd_t;

	isam_cd_t st_reg;
	isam_cd_t st_next;

	always_comb
	begin
		st_next.sclD = sclIn;
		st_next.sdaD = sdaIn;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			st_reg <= '1;
		else
			st_reg <= st_next;
	end

	always_comb
	begin
		cond.sclLevel = sclIn;
		cond.sdaLevel = sdaIn;
		cond.sclRise  = sclIn & ~st_reg.sclD;
		cond.sclFall  = ~sclIn & st_reg.sclD;
		// data moving while clock is high marks a bus condition
		cond.startDet = sclIn & st_reg.sclD & st_reg.sdaD & ~sdaIn;
		cond.stopDet  = sclIn & st_reg.sclD & ~st_reg.sdaD & sdaIn;
	end
endmodule

// ===== tb/isam_bus_model.sv
/*
 * Behavioural two-wire bus master driving the clock and data pins.
 * Assumes pull-ups on both lines; the clock stands high between frames.
 */
`timescale 1ns/10ps
module isam_bus_model
(
	output logic scl,
	output logic sda
);
	localparam int Q = 20;

	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// also a repeated start when entered with the clock low
	task automatic start();
		sda = 1'b1;
		#Q scl = 1'b1;
		#Q sda = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask

	// ninth clock with data released, so the pull-up reads back high
	task automatic sendByte(input logic [7:0] b);
		for (int i = 8; i >= 0; i--)
		begin
			sda = (i == 0) ? 1'b1 : b[i-1];
			#Q scl = 1'b1;
			#(2*Q) scl = 1'b0;
			#Q;
		end
	endtask

	task automatic stop();
		sda = 1'b0;
		#Q scl = 1'b1;
		#Q sda = 1'b1;
		#(2*Q);
	endtask
endmodule

// ===== tb/isam_top_tb.sv
/*
 * Self-checking bench for the status flag and address mask block.
 * Assumes the bus model drives the pins and the bench plays shift engine.
 */
`timescale 1ns/10ps
module isam_top_tb
	import isam_pkg::*;
();
	logic        clk_sys;
	logic        srst;
	logic [3:0]  regAddr;
	logic [15:0] regWdata;
	logic        regWr;
	logic        regRd;
	logic [15:0] regRdata;
	logic        scl;
	logic        sda;
	logic        masterCollision;
	logic        txDone;
	logic        txBusy;
	logic [7:0]  txByte;
	logic        txStart;
	logic        addrHit;
	logic        irq;
	int          err_count;
	int          comparisons;
	logic [7:0]  tByte [3] = '{8'hA2, 8'hA3, 8'h00};
	logic [15:0] tMask [3] = '{16'h0000, 16'h0001, 16'h0000};
	logic        tHit  [3] = '{1'b0, 1'b1, 1'b1};
	logic [15:0] tStat [3] = '{16'h0000, 16'h0004, 16'h0200};

	isam_top DUT
	(
		.clk_sys         (clk_sys),
		.srst            (srst),
		.regAddr         (regAddr),
		.regWdata        (regWdata),
		.regWr           (regWr),
		.regRd           (regRd),
		.regRdata        (regRdata),
		.sclPin          (scl),
		.sdaPin          (sda),
		.masterCollision (masterCollision),
		.txDone          (txDone),
		.txBusy          (txBusy),
		.txByte          (txByte),
		.txStart         (txStart),
		.addrHit         (addrHit),
		.irq             (irq)
	);

	isam_bus_model bm
	(
		.scl (scl),
		.sda (sda)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	function automatic logic [15:0] bv(input int b);
		return 16'h0001 << b;
	endfunction

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	task automatic rdChk(input logic [3:0] a, input logic [15:0] m,
		input logic [15:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		chk(regRdata & m, exp);
	endtask

	task automatic summarize();
		$display("errors=%0d comparisons=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#60000;
		err_count++;
		summarize();
	end

	initial
	begin
		err_count = 0;
		comparisons = 0;
		srst = 1'b1;
		regAddr = 4'h0;
		regWdata = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		masterCollision = 1'b0;
		txDone = 1'b0;
		txBusy = 1'b0;
		idle(8);
		srst <= 1'b0;
		rdChk(OFF_STATUS, 16'hFFFF, RST_STATUS);
		rdChk(OFF_MASK, 16'hFFFF, RST_MASK);
		wr(OFF_MASK, 16'hFFFF);
		rdChk(OFF_MASK, 16'hFFFF, 16'h03FF);
		wr(4'hF, 16'hFFFF);
		rdChk(4'hF, 16'hFFFF, 16'h0000);
		wr(OFF_TXHOLD, 16'h005A);
		@(negedge clk_sys);
		chk({15'h0000, txStart}, 16'h0001);
		chk({8'h00, txByte}, 16'h005A);
		rdChk(OFF_STATUS, bv(BIT_TXFULL), bv(BIT_TXFULL));
		wr(OFF_TXHOLD, 16'h00C3);
		rdChk(OFF_STATUS, bv(BIT_WCOL), bv(BIT_WCOL));
		chk({8'h00, txByte}, 16'h005A);
		@(posedge clk_sys);
		txDone <= 1'b1;
		@(posedge clk_sys);
		txDone <= 1'b0;
		rdChk(OFF_STATUS, bv(BIT_TXFULL), 16'h0000);
		wr(OFF_STATUS, bv(BIT_WCOL));
		rdChk(OFF_STATUS, bv(BIT_WCOL), 16'h0000);
		// busy engine refuses a write even with the holding register empty
		txBusy <= 1'b1;
		wr(OFF_TXHOLD, 16'h0011);
		rdChk(OFF_STATUS, bv(BIT_WCOL), bv(BIT_WCOL));
		txBusy <= 1'b0;
		wr(OFF_STATUS, bv(BIT_WCOL));
		wr(OFF_IRQMASK, bv(EV_START));
		@(posedge clk_sys);
		masterCollision <= 1'b1;
		@(posedge clk_sys);
		masterCollision <= 1'b0;
		rdChk(OFF_STATUS, bv(BIT_BUSCOL), bv(BIT_BUSCOL));
		chk({15'h0000, irq}, 16'h0000);
		wr(OFF_STATUS, bv(BIT_BUSCOL));
		rdChk(OFF_STATUS, bv(BIT_BUSCOL), 16'h0000);
		wr(OFF_SLVADDR, 16'h0050);
		wr(OFF_MASK, 16'h0000);
		bm.start();
		idle(6);
		rdChk(OFF_STATUS, 16'h0018, bv(BIT_START));
		chk({15'h0000, irq}, 16'h0001);
		wr(OFF_IRQSTAT, bv(EV_START));
		idle(1);
		@(negedge clk_sys);
		chk({15'h0000, irq}, 16'h0000);
		bm.sendByte(8'hA0);
		idle(3);
		chk({15'h0000, addrHit}, 16'h0001);
		rdChk(OFF_STATUS, 16'h0024, 16'h0000);
		bm.sendByte(8'hA5);
		rdChk(OFF_STATUS, 16'h0022, 16'h0022);
		// second byte before software read: held byte must survive
		bm.sendByte(8'h3C);
		rdChk(OFF_STATUS, bv(BIT_RXOVF), bv(BIT_RXOVF));
		rdChk(OFF_RXHOLD, 16'h00FF, 16'h00A5);
		rdChk(OFF_STATUS, bv(BIT_RXFULL), 16'h0000);
		bm.stop();
		idle(6);
		rdChk(OFF_STATUS, 16'h0018, bv(BIT_STOP));
		chk({15'h0000, addrHit}, 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFF_MASK, tMask[i]);
			bm.start();
			bm.sendByte(tByte[i]);
			idle(3);
			chk({15'h0000, addrHit}, {15'h0000, tHit[i]});
			rdChk(OFF_STATUS, 16'h0204, tStat[i]);
			bm.stop();
			idle(6);
			rdChk(OFF_STATUS, bv(BIT_GCALL), 16'h0000);
		end
		// ten-bit write addressing, then a read turn after repeated start
		wr(OFF_SLVADDR, 16'h06A5);
		bm.start();
		bm.sendByte(8'hF4);
		bm.sendByte(8'hA5);
		idle(3);
		chk({15'h0000, addrHit}, 16'h0001);
		rdChk(OFF_STATUS, 16'h0124, 16'h0100);
		bm.start();
		bm.sendByte(8'hF5);
		idle(3);
		chk({15'h0000, addrHit}, 16'h0001);
		rdChk(OFF_STATUS, 16'h0124, 16'h0104);
		bm.stop();
		idle(6);
		rdChk(OFF_STATUS, bv(BIT_TENBIT), 16'h0000);
		summarize();
	end
endmodule
